// *** logic/ttc_pkg.sv ***
// package: register map, field positions and carrier types for thermal trip control
package ttc_pkg;

   // ****************************************************************
   // register offsets (byte addresses within the controller space)
   // ****************************************************************
   localparam logic [11:0] OFF_TRIP   = 12'hcdc; // trip_point_targets
   localparam logic [11:0] OFF_LIVE   = 12'hcda; // live_trip_indicators
   localparam logic [11:0] OFF_CAL    = 12'hce2; // calibration_offset_lock
   localparam logic [11:0] OFF_THR    = 12'hce4; // hardware_throttle_control
   localparam logic [11:0] OFF_STAT   = 12'hcea; // thermal_event_status
   localparam logic [11:0] OFF_SMICMD = 12'hcf1; // hot_trip_smi_enable holder

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int TRIP_HOT_LSB   = 8;
   localparam int TRIP_CAT_LSB   = 0;
   localparam int CAL_LOCK_BIT   = 7;
   localparam int THR_HALT_BIT   = 3;
   localparam int THR_LOCK_BIT   = 0;
   localparam int ST_CAT_FALL    = 9;
   localparam int ST_HOT_FALL    = 8;
   localparam int ST_CAT_RISE    = 4;
   localparam int ST_HOT_RISE    = 3;
   localparam int LIVE_CAT_BIT   = 7;
   localparam int LIVE_HOT_BIT   = 6;
   localparam int SMI_EN_BIT     = 1;

   // ****************************************************************
   // reset values and writable masks
   // ****************************************************************
   localparam logic [15:0] TRIP_RST   = 16'h0000;
   localparam logic [6:0]  CAL_RST    = 7'h00;
   localparam logic [15:0] STAT_MASK  = 16'h0318;
   localparam logic [7:0]  THR_MASK   = 8'h09;
   localparam int          DAC_W      = 9;

   // register bus request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [31:0] wdata;
   } ttc_req_t;

   // sensor compare outcome
   typedef struct packed {
      logic cat_above;
      logic hot_above;
   } ttc_live_t;

endpackage

// *** logic/ttc_edge_det.sv ***
// module: crossing detector, turns a synchronised level into rise and fall pulses
`timescale 1ns/100ps
`default_nettype none
module ttc_edge_det (
   input  wire logic clock,
   input  wire logic reset,
   input  wire logic level,
   output logic      rise,
   output logic      fall
);
   logic prev_q;

   // remember last level; reset to low so a hot start shows as a rise
   always_ff @(posedge clock) begin
      if (reset) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= level;
      end
   end

   assign rise = level & ~prev_q;
   assign fall = ~level & prev_q;
endmodule
`default_nettype wire

// *** logic/ttc_dac_sum.sv ***
// module: adds the sign-extended calibration offset to the temperature count
`timescale 1ns/100ps
`default_nettype none
module ttc_dac_sum #(
   parameter int W = ttc_pkg::DAC_W
) (
   input  wire logic [7:0]   count,
   input  wire logic [6:0]   offset,
   output logic      [W-1:0] sum
);
   logic [W-1:0] off_ext;
   logic [W-1:0] cnt_ext;

   // top bit copied upward; 41h..7fh become -3fh..-1
   assign off_ext = {{(W-7){offset[6]}}, offset};
   assign cnt_ext = {{(W-8){1'b0}}, count};
   // wraps modulo 2**W, the dac takes the low bits as is
   assign sum     = cnt_ext + off_ext;
endmodule
`default_nettype wire

// *** logic/ttc_top.sv ***
// module: thermal trip control register bank with trip events and sys mgmt irq
// Functional notes
// - hot target bits 15:8, compared to temperature
// - catastrophic target bits 7:0, lock gated
// - catastrophic lock freezes calibration and trip targets
// - lock on platform reset, offset on power-good
// - signed offset plus counter drives the dac
// - offset loaded from fuses, still writable
// - offset sign-extended to nine bits
// - halt-on-catastrophic stops clocks until platform reset
// - throttle lock freezes throttle register, write-once
// - throttle and status cleared by platform reset
// - status 4 set on catastrophic rise
// - status 3 set on hot rise
// - status 9 set on catastrophic fall
// - status 8 set on hot fall
// - status bits clear only by writing one or by platform reset
// - hot rise raises system management interrupt
// - live bits 7 and 6 show above-target
// - smi enable bit 1 gates hot interrupt
`timescale 1ns/100ps
`default_nettype none
module ttc_top #(
   parameter int ADDR_W = 12,
   parameter int DAC_W  = ttc_pkg::DAC_W
) (
   input  wire logic              clock,
   input  wire logic              reset,
   input  wire logic              core_power_good_reset,
   input  wire logic              platform_reset_n,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]       reg_wdata,
   output logic      [31:0]       reg_rdata,
   output logic                   reg_ack,
   input  wire logic [6:0]        fuse_offset,
   input  wire logic [7:0]        temp_count,
   input  wire logic [7:0]        sensed_temp,
   output logic      [DAC_W-1:0]  dac_code,
   output logic                   sys_mgmt_irq_n,
   output logic                   clock_halt
);

   // ****************************************************************
   // resets and request
   // ****************************************************************
   logic             plat_rst;
   logic             core_rst;
   ttc_pkg::ttc_req_t req;

   // either reset source also honours the local reset
   assign plat_rst = reset | ~platform_reset_n;
   assign core_rst = reset | core_power_good_reset;
   assign req      = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

   // ****************************************************************
   // sensor input synchronisation
   // ****************************************************************
   logic [7:0] temp_s1_q;
   logic [7:0] temp_s2_q;

   // analog side is asynchronous; a multi-bit skew only shifts the compare by a cycle
   always_ff @(posedge clock) begin
      temp_s1_q <= sensed_temp;
      temp_s2_q <= temp_s1_q;
   end

   // ****************************************************************
   // trip targets and calibration
   // ****************************************************************
   logic [7:0] hot_target_q;
   logic [7:0] catastrophic_target_q;
   logic [6:0] calib_offset_q;
   logic       catastrophic_lock_q;
   logic       fuse_load_q;
   logic       wr_trip;
   logic       wr_cal;

   assign wr_trip = req.wr && req.addr == ttc_pkg::OFF_TRIP;
   assign wr_cal  = req.wr && req.addr == ttc_pkg::OFF_CAL;

   // targets live on power-good; writes dropped once locked
   always_ff @(posedge clock) begin
      if (core_rst) begin
         hot_target_q          <= ttc_pkg::TRIP_RST[15:8];
         catastrophic_target_q <= ttc_pkg::TRIP_RST[7:0];
      end else if (wr_trip && !catastrophic_lock_q) begin
         hot_target_q          <= req.wdata[ttc_pkg::TRIP_HOT_LSB +: 8];
         catastrophic_target_q <= req.wdata[ttc_pkg::TRIP_CAT_LSB +: 8];
      end
   end

   // offset on power-good, fuses copied in the cycle after release
   always_ff @(posedge clock) begin
      if (core_rst) begin
         calib_offset_q <= ttc_pkg::CAL_RST;
         fuse_load_q    <= 1'b1;
      end else if (fuse_load_q) begin
         calib_offset_q <= fuse_offset;
         fuse_load_q    <= 1'b0;
      end else if (wr_cal && !catastrophic_lock_q) begin
         calib_offset_q <= req.wdata[6:0];
      end
   end

   // lock is write-once; only platform reset clears it
   always_ff @(posedge clock) begin
      if (plat_rst) begin
         catastrophic_lock_q <= 1'b0;
      end else if (wr_cal && req.wdata[ttc_pkg::CAL_LOCK_BIT]) begin
         catastrophic_lock_q <= 1'b1;
      end
   end

   // ****************************************************************
   // dac code
   // ****************************************************************
   logic [DAC_W-1:0] dac_sum;

   ttc_dac_sum #(
      .W (DAC_W)
   ) u_sum (
      .count  (temp_count),
      .offset (calib_offset_q),
      .sum    (dac_sum)
   );

   // registered so the output leaves from a flop
   always_ff @(posedge clock) begin
      if (core_rst) begin
         dac_code <= '0;
      end else begin
         dac_code <= dac_sum;
      end
   end

   // ****************************************************************
   // live compare and crossings
   // ****************************************************************
   ttc_pkg::ttc_live_t live_q;
   logic               hot_rise;
   logic               hot_fall;
   logic               cat_rise;
   logic               cat_fall;

   // strictly above target counts as tripped
   always_ff @(posedge clock) begin
      if (core_rst) begin
         live_q <= '0;
      end else begin
         live_q.hot_above <= temp_s2_q > hot_target_q;
         live_q.cat_above <= temp_s2_q > catastrophic_target_q;
      end
   end

   ttc_edge_det u_hot (
      .clock (clock),
      .reset (core_rst),
      .level (live_q.hot_above),
      .rise  (hot_rise),
      .fall  (hot_fall)
   );

   ttc_edge_det u_cat (
      .clock (clock),
      .reset (core_rst),
      .level (live_q.cat_above),
      .rise  (cat_rise),
      .fall  (cat_fall)
   );

   // ****************************************************************
   // throttle control and smi enable
   // ****************************************************************
   logic halt_on_catastrophic_q;
   logic throttle_lock_q;
   logic hot_trip_smi_enable_q;
   logic wr_thr;

   assign wr_thr = req.wr && req.addr == ttc_pkg::OFF_THR;

   // whole register frozen once the lock is set
   always_ff @(posedge clock) begin
      if (plat_rst) begin
         halt_on_catastrophic_q <= 1'b0;
         throttle_lock_q        <= 1'b0;
      end else if (wr_thr && !throttle_lock_q) begin
         halt_on_catastrophic_q <= req.wdata[ttc_pkg::THR_HALT_BIT];
         throttle_lock_q        <= req.wdata[ttc_pkg::THR_LOCK_BIT];
      end
   end

   // smi enable, platform reset domain
   always_ff @(posedge clock) begin
      if (plat_rst) begin
         hot_trip_smi_enable_q <= 1'b0;
      end else if (req.wr && req.addr == ttc_pkg::OFF_SMICMD) begin
         hot_trip_smi_enable_q <= req.wdata[ttc_pkg::SMI_EN_BIT];
      end
   end

   // halt holds until platform reset; mode sampled at the trip itself
   always_ff @(posedge clock) begin
      if (plat_rst) begin
         clock_halt <= 1'b0;
      end else if (cat_rise && halt_on_catastrophic_q) begin
         clock_halt <= 1'b1;
      end
   end

   // ****************************************************************
   // event status, write one to clear
   // ****************************************************************
   logic [15:0] status_q;
   logic [15:0] status_set;
   logic [15:0] status_clr;

   always_comb begin
      status_set                       = '0;
      status_set[ttc_pkg::ST_CAT_RISE] = cat_rise;
      status_set[ttc_pkg::ST_HOT_RISE] = hot_rise;
      status_set[ttc_pkg::ST_CAT_FALL] = cat_fall;
      status_set[ttc_pkg::ST_HOT_FALL] = hot_fall;
   end

   assign status_clr = (req.wr && req.addr == ttc_pkg::OFF_STAT) ?
                       req.wdata[15:0] : 16'h0000;

   // a new event in the clear cycle wins, so nothing is lost
   always_ff @(posedge clock) begin
      if (plat_rst) begin
         status_q <= 16'h0000;
      end else begin
         status_q <= ((status_q & ~status_clr) | status_set) & ttc_pkg::STAT_MASK;
      end
   end

   // ****************************************************************
   // system management interrupt
   // ****************************************************************
   // level while the hot rise flag stands; software rereads live bits after clearing
   always_ff @(posedge clock) begin
      if (plat_rst) begin
         sys_mgmt_irq_n <= 1'b1;
      end else begin
         sys_mgmt_irq_n <= ~(hot_trip_smi_enable_q &&
                             (status_q[ttc_pkg::ST_HOT_RISE] || hot_rise));
      end
   end

   // ****************************************************************
   // read path
   // ****************************************************************
   logic [31:0] rdata_d;

   // unmapped and reserved bits read zero
   always_comb begin
      rdata_d = 32'h0000_0000;
      case (req.addr)
         ttc_pkg::OFF_TRIP: begin
            rdata_d[15:0] = {hot_target_q, catastrophic_target_q};
         end
         ttc_pkg::OFF_LIVE: begin
            rdata_d[ttc_pkg::LIVE_CAT_BIT] = live_q.cat_above;
            rdata_d[ttc_pkg::LIVE_HOT_BIT] = live_q.hot_above;
         end
         ttc_pkg::OFF_CAL: begin
            rdata_d[7:0] = {catastrophic_lock_q, calib_offset_q};
         end
         ttc_pkg::OFF_THR: begin
            rdata_d[ttc_pkg::THR_HALT_BIT] = halt_on_catastrophic_q;
            rdata_d[ttc_pkg::THR_LOCK_BIT] = throttle_lock_q;
         end
         ttc_pkg::OFF_STAT: begin
            rdata_d[15:0] = status_q;
         end
         ttc_pkg::OFF_SMICMD: begin
            rdata_d[ttc_pkg::SMI_EN_BIT] = hot_trip_smi_enable_q;
         end
         default: begin
            rdata_d = 32'h0000_0000;
         end
      endcase
   end

   // one-cycle answer, data held until the next read
   always_ff @(posedge clock) begin
      if (reset) begin
         reg_rdata <= 32'h0000_0000;
         reg_ack   <= 1'b0;
      end else begin
         reg_ack <= req.wr | req.rd;
         if (req.rd) begin
            reg_rdata <= rdata_d;
         end
      end
   end

endmodule
`default_nettype wire

// *** testbench/ttc_top_sva.sv ***
// checker: port-level properties of the thermal trip control bank
`timescale 1ns/100ps
`default_nettype none
module ttc_top_sva #(
   parameter int ADDR_W = 12,
   parameter int DAC_W  = 9
) (
   input wire logic              clock,
   input wire logic              reset,
   input wire logic              core_power_good_reset,
   input wire logic              platform_reset_n,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0]       reg_wdata,
   input wire logic [31:0]       reg_rdata,
   input wire logic              reg_ack,
   input wire logic [6:0]        fuse_offset,
   input wire logic [7:0]        temp_count,
   input wire logic [7:0]        sensed_temp,
   input wire logic [DAC_W-1:0]  dac_code,
   input wire logic              sys_mgmt_irq_n,
   input wire logic              clock_halt
);
   // ****************************************************************
   // read decode and properties
   // ****************************************************************
   logic mapped;
   // exact-match decode, anything else must read back as zero
   assign mapped = reg_addr inside {ttc_pkg::OFF_TRIP, ttc_pkg::OFF_LIVE, ttc_pkg::OFF_CAL,
                                    ttc_pkg::OFF_THR, ttc_pkg::OFF_STAT, ttc_pkg::OFF_SMICMD};
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   property p_unmapped; reg_rd && !mapped |=> reg_rdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_trip_rsv; reg_rd && reg_addr == ttc_pkg::OFF_TRIP |=> reg_rdata[31:16] == 16'h0;
   endproperty
   a_trip_rsv: assert property (p_trip_rsv) else $error("trip reserved bits set");
   property p_cal_rsv; reg_rd && reg_addr == ttc_pkg::OFF_CAL |=> reg_rdata[31:8] == 24'h0;
   endproperty
   a_cal_rsv: assert property (p_cal_rsv) else $error("offset reserved bits set");
   property p_thr_rsv; reg_rd && reg_addr == ttc_pkg::OFF_THR |=> reg_rdata[31:0] inside {
      32'h0, 32'h1, 32'h8, 32'h9}; endproperty
   a_thr_rsv: assert property (p_thr_rsv) else $error("throttle reserved bits set");
   property p_stat_rsv; reg_rd && reg_addr == ttc_pkg::OFF_STAT |=>
      (reg_rdata & ~{16'h0, ttc_pkg::STAT_MASK}) == 32'h0; endproperty
   a_stat_rsv: assert property (p_stat_rsv) else $error("status reserved bits set");
   property p_live_rsv; reg_rd && reg_addr == ttc_pkg::OFF_LIVE |=>
      reg_rdata[5:0] == 6'h0 && reg_rdata[31:8] == 24'h0; endproperty
   a_live_rsv: assert property (p_live_rsv) else $error("live reserved bits set");
   property p_halt_sticky; $rose(clock_halt) && platform_reset_n |=> clock_halt; endproperty
   a_halt_sticky: assert property (p_halt_sticky) else $error("halt dropped");
   property p_plat_clear; !platform_reset_n |=> !clock_halt && sys_mgmt_irq_n; endproperty
   a_plat_clear: assert property (p_plat_clear) else $error("platform reset missed");
endmodule
bind ttc_top ttc_top_sva #(.ADDR_W(ADDR_W), .DAC_W(DAC_W)) i_sva (.clock(clock), .reset(reset),
   .core_power_good_reset(core_power_good_reset), .platform_reset_n(platform_reset_n),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .reg_ack(reg_ack), .fuse_offset(fuse_offset),
   .temp_count(temp_count), .sensed_temp(sensed_temp), .dac_code(dac_code),
   .sys_mgmt_irq_n(sys_mgmt_irq_n), .clock_halt(clock_halt));
`default_nettype wire

// *** testbench/thermal_trip_control_test.sv ***
// testbench: register accesses and trip events for thermal trip control
`timescale 1ns/100ps
`default_nettype none
module thermal_trip_control_test;
   logic        clock, reset, core_power_good_reset, platform_reset_n;
   logic        reg_wr, reg_rd, reg_ack, sys_mgmt_irq_n, clock_halt;
   logic [11:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [6:0]  fuse_offset;
   logic [7:0]  temp_count, sensed_temp;
   logic [8:0]  dac_code;
   int          fail_count, samples_checked;

   ttc_top i_dut (.clock(clock), .reset(reset), .core_power_good_reset(core_power_good_reset),
      .platform_reset_n(platform_reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
      .fuse_offset(fuse_offset), .temp_count(temp_count), .sensed_temp(sensed_temp),
      .dac_code(dac_code), .sys_mgmt_irq_n(sys_mgmt_irq_n), .clock_halt(clock_halt));

   // 100 ns clock
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // ****************************************************************
   // compare and bus tasks
   // ****************************************************************
   task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check1(input string what, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s expected %b seen %b", what, exp, got);
      end
   endtask
   // inputs always move 1 ns after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // an extra idle cycle keeps strobes from being reassigned in one step
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      reg_addr = a;
      reg_rd = 1'b1;
      tick(1);
      reg_rd = 1'b0;
      check1("ack", 1'b1, reg_ack);
      check32("rdata", exp, reg_rdata);
      tick(1);
   endtask
   // synchroniser plus compare plus status is about four cycles
   task automatic temp(input logic [7:0] t);
      sensed_temp = t;
      tick(8);
   endtask
   task automatic wait_irq(input logic lvl);
      int n;
      n = 0;
      while (sys_mgmt_irq_n !== lvl && n < 20) begin
         tick(1);
         n++;
      end
      check1("irq_n", lvl, sys_mgmt_irq_n);
      // bound used up without the level: mismatch already counted, close the run
      if (sys_mgmt_irq_n !== lvl) begin
         print_verdict();
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      reset = 1'b1;
      core_power_good_reset = 1'b1;
      platform_reset_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 12'h000;
      reg_wdata = 32'h0;
      fuse_offset = 7'h45;
      temp_count = 8'h20;
      sensed_temp = 8'h00;
      fail_count = 0;
      samples_checked = 0;
      tick(12);
      reset = 1'b0;
      core_power_good_reset = 1'b0;
      platform_reset_n = 1'b1;
      tick(2);
      rd(ttc_pkg::OFF_TRIP, 32'h0);
      rd(ttc_pkg::OFF_CAL, 32'h45);
      rd(ttc_pkg::OFF_THR, 32'h0);
      rd(ttc_pkg::OFF_STAT, 32'h0);
      rd(12'hcd0, 32'h0);
      check32("dac", 32'h1e5, {23'h0, dac_code});
      $display("test reset values done");
      wr(ttc_pkg::OFF_TRIP, 32'hffff6090);
      rd(ttc_pkg::OFF_TRIP, 32'h6090);
      wr(ttc_pkg::OFF_SMICMD, 32'hff);
      rd(ttc_pkg::OFF_SMICMD, 32'h02);
      wr(ttc_pkg::OFF_THR, 32'hfe);
      rd(ttc_pkg::OFF_THR, 32'h08);
      wr(ttc_pkg::OFF_THR, 32'h09);
      wr(ttc_pkg::OFF_THR, 32'h00);
      rd(ttc_pkg::OFF_THR, 32'h09);
      $display("test fields and throttle lock done");
      // equal to the hot target is not above it
      temp(8'h60);
      check1("irq_n", 1'b1, sys_mgmt_irq_n);
      temp(8'h70);
      rd(ttc_pkg::OFF_LIVE, 32'h40);
      wait_irq(1'b0);
      rd(ttc_pkg::OFF_STAT, 32'h08);
      check1("halt", 1'b0, clock_halt);
      temp(8'ha0);
      rd(ttc_pkg::OFF_LIVE, 32'hc0);
      rd(ttc_pkg::OFF_STAT, 32'h18);
      check1("halt", 1'b1, clock_halt);
      temp(8'h10);
      rd(ttc_pkg::OFF_STAT, 32'h318);
      check1("halt", 1'b1, clock_halt);
      wr(ttc_pkg::OFF_STAT, 32'h0);
      rd(ttc_pkg::OFF_STAT, 32'h318);
      wr(ttc_pkg::OFF_STAT, 32'h8);
      wait_irq(1'b1);
      rd(ttc_pkg::OFF_LIVE, 32'h0);
      rd(ttc_pkg::OFF_STAT, 32'h310);
      wr(ttc_pkg::OFF_STAT, 32'hffff);
      rd(ttc_pkg::OFF_STAT, 32'h0);
      wr(ttc_pkg::OFF_SMICMD, 32'h0);
      temp(8'h70);
      rd(ttc_pkg::OFF_STAT, 32'h08);
      check1("irq_n", 1'b1, sys_mgmt_irq_n);
      temp(8'h10);
      $display("test trip events done");
      wr(ttc_pkg::OFF_CAL, 32'h05);
      wr(ttc_pkg::OFF_CAL, 32'h85);
      wr(ttc_pkg::OFF_CAL, 32'h00);
      wr(ttc_pkg::OFF_TRIP, 32'h0);
      rd(ttc_pkg::OFF_CAL, 32'h85);
      rd(ttc_pkg::OFF_TRIP, 32'h6090);
      temp_count = 8'hfe;
      tick(3);
      check32("dac", 32'h103, {23'h0, dac_code});
      $display("test catastrophic lock done");
      platform_reset_n = 1'b0;
      tick(1);
      platform_reset_n = 1'b1;
      tick(1);
      rd(ttc_pkg::OFF_CAL, 32'h05);
      rd(ttc_pkg::OFF_THR, 32'h0);
      rd(ttc_pkg::OFF_STAT, 32'h0);
      check1("halt", 1'b0, clock_halt);
      rd(ttc_pkg::OFF_TRIP, 32'h6090);
      wr(ttc_pkg::OFF_CAL, 32'h0a);
      rd(ttc_pkg::OFF_CAL, 32'h0a);
      core_power_good_reset = 1'b1;
      tick(1);
      core_power_good_reset = 1'b0;
      tick(2);
      rd(ttc_pkg::OFF_TRIP, 32'h0);
      rd(ttc_pkg::OFF_CAL, 32'h45);
      // targets back at zero while sensed sits above them: both rise, halt disabled
      rd(ttc_pkg::OFF_STAT, 32'h18);
      check1("halt", 1'b0, clock_halt);
      $display("test reset domains done");
      print_verdict();
   end
endmodule
`default_nettype wire
